// ==== rtl/pmc_pkg.sv ====
// package: register map, field positions and mode codes of the power mode control block
package pmc_pkg;
  localparam logic [7:0] PMC_OFF_CTRL = 8'h00;
  localparam logic [7:0] PMC_OFF_SCR0 = 8'h04;
  localparam logic [7:0] PMC_OFF_SCR1 = 8'h08;
  localparam logic [7:0] PMC_OFF_SCR2 = 8'h0c;
  localparam logic [7:0] PMC_OFF_SCR3 = 8'h10;
  localparam logic [7:0] PMC_OFF_DPDC = 8'h14;
  localparam int PMC_NUM_SCR = 4;
  localparam int PMC_ADDR_W = 8;
  localparam int PMC_PM_LO = 0;
  localparam int PMC_PM_HI = 2;
  localparam int PMC_BLK_BIT = 3;
  localparam int PMC_LPF_BIT = 8;
  localparam int PMC_DPF_BIT = 11;
  localparam logic [31:0] PMC_RESET_WORD = 32'h0000_0000;
  typedef enum logic [2:0] {
    PMC_PM_ACTIVE = 3'h0,
    PMC_PM_DSLEEP = 3'h1,
    PMC_PM_PDOWN = 3'h2,
    PMC_PM_DPD = 3'h3
  } pmc_mode_t;
  // entry status codes, gray along idle -> low entered -> back to idle; dpd entry flips both bits
  typedef enum logic [1:0] {
    PMC_ST_RUN = 2'b00,
    PMC_ST_LOW = 2'b01,
    PMC_ST_DPD = 2'b11
  } pmc_state_t;
endpackage

// ==== rtl/pmc_regs.sv ====
// module: power mode control register bank with apb slave and mode entry
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
// ****************************************************************
// power mode control registers
// ****************************************************************
// Summary of operation
// R1: three-bit mode select at bits 2:0, reset zero; zero means active or sleep.
// R2: mode 1 plus wait-for-interrupt enters deep-sleep.
// R3: mode 2 plus wait-for-interrupt enters power-down.
// R4: mode 3 plus wait-for-interrupt enters deep power-down, core off; the code also needs core_deep_sleep_request high, else it enters sleep.
// R5: block bit 3 set refuses deep power-down entry.
// R6: block bit sticks once written one; only power-on reset clears it.
// R7: software writes zeros to reserved bits; they read zero.
// R8: bit 8 flags sleep, deep-sleep or power-down entry; resets zero.
// R9: writing one clears the low-power flag; zero has no effect.
// R10: bit 11 flags deep power-down entry; write one clears it.
// R11: four read/write scratch words at 0x004 to 0x010, reset zero.
// R12: deep power-down control word at 0x014, read/write, reset zero.
// R13: scratch words survive deep power-down; only cold boot resets them.
// R14: control word bits 31:4 retained like the scratch words.
// R15: waking from deep power-down reboots; only retained words survive.
// R16: aligned 32-bit word access over one slave port, one-access reads.
module pmc_regs
  import pmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_deep_sleep_request,
  input wire logic wait_for_interrupt_instr,
  input wire logic reboot_from_dpd,
  output logic [2:0] power_mode_select,
  output logic deep_powerdown_block,
  output logic enter_sleep,
  output logic enter_deep_sleep,
  output logic enter_power_down,
  output logic enter_deep_powerdown,
  output logic [31:0] deep_powerdown_control
);
  // ****************************************************************
  // register state
  // ****************************************************************
  logic [2:0] pm_q, pm_d;
  logic blk_q, blk_d;
  logic lpf_q, lpf_d;
  logic dpf_q, dpf_d;
  logic [31:0] scr_q [PMC_NUM_SCR];
  logic [31:0] scr_d [PMC_NUM_SCR];
  logic [31:0] dpdc_q, dpdc_d;
  logic [31:0] prdata_q, prdata_d;
  logic slverr_q, slverr_d;
  pmc_state_t st_q, st_d;
  logic [3:0] ent_pulse_q, ent_pulse_d;
  logic wr_acc, rd_acc, hit;
  logic go_sleep, go_dsleep, go_pdown, go_dpd;

  // no wait states: every access completes in its first access cycle
  assign pready = 1'b1; // [R16]
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;

  always_comb
  begin
    hit = 1'b1;
    unique case (paddr)
      PMC_OFF_CTRL, PMC_OFF_SCR0, PMC_OFF_SCR1, PMC_OFF_SCR2,
      PMC_OFF_SCR3, PMC_OFF_DPDC: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // mode entry decode
  // ****************************************************************
  // entry fires in every cycle wait_for_interrupt_instr is high; the block bit only gates dpd
  always_comb
  begin
    go_sleep = 1'b0;
    go_dsleep = 1'b0;
    go_pdown = 1'b0;
    go_dpd = 1'b0;
    if (wait_for_interrupt_instr)
    begin
      unique case (pm_q)
        PMC_PM_DSLEEP: go_dsleep = 1'b1; // [R2]
        PMC_PM_PDOWN: go_pdown = 1'b1; // [R3]
        PMC_PM_DPD:
        begin
          // refused entry falls back to ordinary sleep
          if (core_deep_sleep_request && !blk_q)
            go_dpd = 1'b1; // [R4] [R5]
          else
            go_sleep = 1'b1;
        end
        default: go_sleep = 1'b1; // [R1]
      endcase
    end
  end

  always_comb
  begin
    ent_pulse_d = {go_dpd, go_pdown, go_dsleep, go_sleep};
    if (go_dpd)
      st_d = PMC_ST_DPD;
    else if (go_sleep || go_dsleep || go_pdown)
      st_d = PMC_ST_LOW;
    else
      st_d = PMC_ST_RUN;
  end

  // ****************************************************************
  // retained scratch words
  // ****************************************************************
  // one decoder per word; the stride is the spacing of the word offsets
  for (genvar g = 0; g < PMC_NUM_SCR; g++)
  begin : g_scr
    always_comb
    begin
      scr_d[g] = scr_q[g];
      if (wr_acc && paddr == PMC_OFF_SCR0 + 8'(g) *
        (PMC_OFF_SCR1 - PMC_OFF_SCR0))
        scr_d[g] = pwdata; // [R11] [R13]
    end
  end

  // ****************************************************************
  // register updates
  // ****************************************************************
  always_comb
  begin
    pm_d = pm_q;
    blk_d = blk_q;
    lpf_d = lpf_q;
    dpf_d = dpf_q;
    dpdc_d = dpdc_q;
    prdata_d = prdata_q;
    slverr_d = 1'b0;
    if (wr_acc)
    begin
      unique case (paddr)
        PMC_OFF_CTRL:
        begin
          pm_d = pwdata[PMC_PM_HI:PMC_PM_LO]; // [R1]
          blk_d = blk_q | pwdata[PMC_BLK_BIT]; // [R6]
          if (pwdata[PMC_LPF_BIT])
            lpf_d = 1'b0; // [R9]
          if (pwdata[PMC_DPF_BIT])
            dpf_d = 1'b0; // [R10]
        end
        PMC_OFF_DPDC: dpdc_d = pwdata; // [R12] [R14]
        default: slverr_d = 1'b0;
      endcase
    end
    // a set in the same cycle as a write-one clear wins
    if (go_sleep || go_dsleep || go_pdown)
      lpf_d = 1'b1; // [R8]
    if (go_dpd || reboot_from_dpd)
      dpf_d = 1'b1; // [R10]
    // reboot after dpd clears only non-retained state
    if (reboot_from_dpd)
    begin
      pm_d = PMC_PM_ACTIVE; // [R15]
      lpf_d = 1'b0;
    end
    if (rd_acc)
    begin
      unique case (paddr)
        PMC_OFF_CTRL:
          prdata_d = {20'h0_0000, dpf_q, 2'h0, lpf_q, 4'h0, blk_q,
            pm_q}; // [R7]
        PMC_OFF_SCR0: prdata_d = scr_q[0];
        PMC_OFF_SCR1: prdata_d = scr_q[1];
        PMC_OFF_SCR2: prdata_d = scr_q[2];
        PMC_OFF_SCR3: prdata_d = scr_q[3];
        PMC_OFF_DPDC: prdata_d = dpdc_q;
        default: prdata_d = PMC_RESET_WORD;
      endcase
    end
    if (psel && !penable)
      slverr_d = ~hit;
  end

  // retained words reset only by presetn, which is the cold-boot reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pm_q <= PMC_PM_ACTIVE;
      blk_q <= 1'b0;
      lpf_q <= 1'b0;
      dpf_q <= 1'b0;
      scr_q <= '{default: PMC_RESET_WORD}; // [R13]
      dpdc_q <= PMC_RESET_WORD;
      prdata_q <= PMC_RESET_WORD;
      slverr_q <= 1'b0;
      st_q <= PMC_ST_RUN;
      ent_pulse_q <= 4'h0;
    end
    else
    begin
      pm_q <= pm_d;
      blk_q <= blk_d;
      lpf_q <= lpf_d;
      dpf_q <= dpf_d;
      scr_q <= scr_d;
      dpdc_q <= dpdc_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
      st_q <= st_d;
      ent_pulse_q <= ent_pulse_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = prdata_q;
  assign pslverr = slverr_q & psel & penable;
  assign power_mode_select = pm_q;
  assign deep_powerdown_block = blk_q;
  assign enter_sleep = ent_pulse_q[0];
  assign enter_deep_sleep = ent_pulse_q[1];
  assign enter_power_down = ent_pulse_q[2];
  assign enter_deep_powerdown = ent_pulse_q[3];
  assign deep_powerdown_control = dpdc_q;
endmodule // pmc_regs

// ==== sim/pmc_core_model.sv ====
// core side model: wait-for-interrupt pulses and deep-sleep level
`timescale 1ns/1ns
module pmc_core_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic deep,
  output logic core_deep_sleep_request = 1'h0,
  output logic wait_for_interrupt_instr = 1'h0
);
  always @(posedge pclk)
  begin
    core_deep_sleep_request <= deep;
    wait_for_interrupt_instr <= go;
  end
endmodule // pmc_core_model

// ==== sim/pmc_regs_checker.sv ====
// port assertions of the power mode control register bank
`timescale 1ns/1ns
module pmc_regs_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pmc_pkg::PMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic core_deep_sleep_request,
  input wire logic wait_for_interrupt_instr,
  input wire logic reboot_from_dpd,
  input wire logic [2:0] power_mode_select,
  input wire logic deep_powerdown_block,
  input wire logic enter_sleep,
  input wire logic enter_deep_sleep,
  input wire logic enter_power_down,
  input wire logic enter_deep_powerdown,
  input wire logic [31:0] deep_powerdown_control
);
  import pmc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic w;
  logic [2:0] pm;
  assign w = wait_for_interrupt_instr;
  assign pm = power_mode_select;
  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a && !reboot_from_dpd;
  endsequence
  sequence s_dpd_go;
    w && pm == 3'h3 && !deep_powerdown_block && core_deep_sleep_request;
  endsequence
  sequence s_dpd_no;
    w && pm == 3'h3 && (deep_powerdown_block || !core_deep_sleep_request);
  endsequence
  a_ds_entry: assert property (w && pm == 3'h1 |=> enter_deep_sleep)
    else $error("no deep-sleep entry");
  a_pd_entry: assert property (w && pm == 3'h2 |=> enter_power_down)
    else $error("no power-down entry");
  a_dpd_entry: assert property (s_dpd_go |=> enter_deep_powerdown)
    else $error("no deep power-down entry");
  a_dpd_refused: assert property (s_dpd_no
    |=> !enter_deep_powerdown && enter_sleep) else $error("dpd not refused");
  a_block_sticky: assert property (deep_powerdown_block |=>
    deep_powerdown_block) else $error("block bit dropped");
  a_pm_write: assert property (s_wr(PMC_OFF_CTRL) |=>
    pm == $past(pwdata[2:0])) else $error("mode field not written");
  a_dpdc_write: assert property (s_wr(PMC_OFF_DPDC) |=>
    deep_powerdown_control == $past(pwdata)) else $error("0x14 not written");
  a_bad_addr: assert property (psel && penable && paddr > 8'h14
    |-> pslverr) else $error("unmapped access not flagged");
endmodule // pmc_regs_checker
bind pmc_regs pmc_regs_checker u_pmc_regs_checker (.*);

// ==== sim/pmc_regs_tb.sv ====
// self-checking bench for the power mode control register bank
`timescale 1ns/1ns
module pmc_regs_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, go = 1'h0, deep = 1'h0, reboot_from_dpd = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, deep_powerdown_control, sv [6];
  logic pready, pslverr, core_deep_sleep_request, wait_for_interrupt_instr;
  logic deep_powerdown_block, enter_sleep, enter_deep_sleep;
  logic enter_power_down, enter_deep_powerdown;
  logic [2:0] power_mode_select;
  logic [32:0] rq [$];
  logic [3:0] eq [$];
  logic [3:0] ent;
  int miscompares = 0, checks = 0, seed = 32'h3628, i;
  assign ent = {enter_sleep, enter_deep_sleep, enter_power_down,
    enter_deep_powerdown};
  always #5 pclk = ~pclk;
  pmc_core_model u_pmc_core_model (.*);
  pmc_regs u_pmc_regs (.*);
  task automatic apb(logic w, logic [7:0] a, logic [32:0] d);
    if (!w)
      rq.push_back(d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // entries come back a few cycles later; the watcher pairs them in order
  task automatic sleep(logic [3:0] e);
    eq.push_back(e);
    @(posedge pclk);
    go <= 1'h1;
    @(posedge pclk);
    go <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask
  // outputs are looked at mid-cycle, where they have settled
  always @(negedge pclk)
  begin
    if (psel && penable && !pwrite && pready === 1'h1)
    begin
      checks++;
      if (rq.size() == 0 || {pslverr, prdata} !== rq.pop_front())
      begin
        miscompares++;
        $display("unexpected %0t read data", $time);
      end
    end
    if (ent !== 4'h0)
    begin
      checks++;
      if (eq.size() == 0 || ent !== eq.pop_front())
      begin
        miscompares++;
        $display("unexpected %0t entry pulse", $time);
      end
    end
  end
  task close_out;
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    close_out;
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    for (i = 0; i < 6; i++)
      apb(1'h0, 8'(4 * i), 33'h0);
    apb(1'h0, 8'h18, 33'h1_0000_0000);
    for (i = 1; i < 6; i++)
    begin
      sv[i] = $random(seed);
      apb(1'h1, 8'(4 * i), {1'h0, sv[i]});
      apb(1'h0, 8'(4 * i), {1'h0, sv[i]});
    end
    for (i = 0; i < 4; i++)
    begin
      apb(1'h1, 8'h0, 33'(i));
      sleep(i % 3 == 0 ? 4'h8 : 4'h4 >> (i - 1));
      apb(1'h0, 8'h0, 33'h100 + 33'(i));
      apb(1'h1, 8'h0, 33'(i));
      apb(1'h0, 8'h0, 33'h100 + 33'(i));
      apb(1'h1, 8'h0, 33'h100 + 33'(i));
      apb(1'h0, 8'h0, 33'(i));
    end
    deep <= 1'h1;
    sleep(4'h1);
    reboot_from_dpd <= 1'h1;
    @(posedge pclk);
    reboot_from_dpd <= 1'h0;
    apb(1'h0, 8'h0, 33'h800);
    for (i = 1; i < 6; i++)
      apb(1'h0, 8'(4 * i), {1'h0, sv[i]});
    apb(1'h1, 8'h0, 33'h800);
    apb(1'h0, 8'h0, 33'h0);
    apb(1'h1, 8'h0, 33'hb);
    apb(1'h1, 8'h0, 33'h3);
    apb(1'h0, 8'h0, 33'hb);
    sleep(4'h8);
    apb(1'h0, 8'h0, 33'h10b);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h0, 33'h0);
    apb(1'h0, 8'h4, 33'h0);
    close_out;
  end
endmodule // pmc_regs_tb
